// ===== pin_sampler.sv
// two-flop synchroniser, edge detect
`default_nettype none

module pin_sampler #(
    parameter int W = 5
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    pin_sync_if.sampler     pins
);

    if (W < 1) begin : g_bad_width
        $error("pin_sampler needs at least one pin");
    end

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] last;
    } smp_s;

    smp_s s_reg;
    smp_s s_next;

    // meta feeds only sync
    always_comb begin
        s_next      = s_reg;
        s_next.meta = pins.raw;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // settled stage vs delayed copy
    assign pins.lvl  = s_reg.sync;
    assign pins.rise = s_reg.sync & ~s_reg.last;
    assign pins.fall = ~s_reg.sync & s_reg.last;

endmodule

`default_nettype wire

// ===== pin_sync_if.sv
// raw pins in, levels and edges out
`default_nettype none

interface pin_sync_if #(
    parameter int W = 5
);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport sampler (input raw, output lvl, output rise, output fall);
    modport user    (output raw, input lvl, input rise, input fall);
endinterface

`default_nettype wire

// ===== spi_partner.sv
// spi slave partner
`default_nettype none
module spi_partner (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       load,
    input  wire logic [7:0] load_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx_sh;
    // capture on leading edge
    always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
    // spent bits come back inverted
    always @(negedge sck or posedge load) begin
        if (load) tx_sh <= load_byte;
        else tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
    end
    assign miso = tx_sh[7];
endmodule
`default_nettype wire

// ===== ssp_checker.sv
// port-level assertions
`default_nettype none
module ssp_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       port_enable_bit,
    input wire logic       i2c_mode,
    input wire logic       master_mode,
    input wire logic       address_hold_enable,
    input wire logic       buf_wr,
    input wire logic [7:0] buf_wdata,
    input wire logic       buf_rd,
    input wire logic       collision_clr,
    input wire logic       ack_release,
    input wire logic       mask_wr,
    input wire logic [7:0] data_buffer,
    input wire logic       buffer_full_flag,
    input wire logic       port_interrupt_flag,
    input wire logic       write_collision_flag,
    input wire logic       update_address_flag,
    input wire logic       general_call_flag,
    input wire logic       busy,
    input wire logic [7:0] address_mask_reg,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       serial_data_out,
    input wire logic       scl_oe
);
    logic       sck_q;
    logic [4:0] edge_cnt;
    logic       spi_m;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign spi_m = master_mode && !i2c_mode && port_enable_bit;
    // sck edges in a transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q    <= 1'h0;
            edge_cnt <= 5'h00;
        end else begin
            sck_q    <= sck_out;
            edge_cnt <= busy ? edge_cnt + 5'(sck_out ^ sck_q) : 5'h00;
        end
    end
    a_enable_gates: assert property (!port_enable_bit |=> !sck_oe && !scl_oe)
        else $error("oe while disabled");
    a_master_start: assert property (buf_wr && !busy && !write_collision_flag && spi_m |=>
        busy && data_buffer == $past(buf_wdata) && serial_data_out == $past(buf_wdata[7]))
        else $error("no start");
    a_collision_set: assert property (buf_wr && busy |=> write_collision_flag)
        else $error("no collision");
    a_collision_block: assert property (buf_wr && write_collision_flag && !collision_clr && !busy && spi_m
        |=> !busy && $stable(data_buffer)) else $error("write passed collision");
    a_read_clears: assert property (buf_rd && !busy && !i2c_mode |=> !buffer_full_flag)
        else $error("full kept");
    a_full_irq: assert property ($rose(buffer_full_flag) |-> port_interrupt_flag)
        else $error("full without irq");
    a_eight_bits: assert property ($fell(busy) && spi_m |-> edge_cnt + 5'(sck_out ^ sck_q) == ssp_pkg::MASTER_EDGES)
        else $error("edge count");
    a_mask_hold: assert property (!mask_wr |=> $stable(address_mask_reg))
        else $error("mask changed");
    a_gc_no_update: assert property ($rose(general_call_flag) |-> !$rose(update_address_flag))
        else $error("gc set update");
    a_hold_stretch: assert property (address_hold_enable && i2c_mode && port_enable_bit && scl_oe
        && !ack_release |=> scl_oe) else $error("early release");
endmodule
bind sync_serial_port ssp_checker u_ssp_checker (.*);
`default_nettype wire

// ===== ssp_pkg.sv
// serial port constants and states
`default_nettype none

package ssp_pkg;

    // pin bit positions
    localparam int PIN_SCK = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_SS  = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_SDA = 4;
    localparam int PIN_W   = 5;

    // master sck half periods
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    // bit and edge counts of one byte
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] ACK_BIT      = 4'h9;
    localparam logic [4:0] MASTER_EDGES = 5'h10;

    // mask reset, general call address
    localparam logic [7:0] MASK_RESET    = 8'hFF;
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'h1,
        SPI_XFER = 2'h2
    } spi_st_e;

    typedef enum logic [4:0] {
        I2C_IDLE = 5'h01,
        I2C_ADDR = 5'h02,
        I2C_DATA = 5'h04,
        I2C_ACK  = 5'h08,
        I2C_SKIP = 5'h10
    } i2c_st_e;

endpackage

`default_nettype wire

// ===== sync_serial_port.sv
// spi engine and i2c address matcher
//
// Notes on behaviour
// R1 - port works only while enable bit set
// R2 - software sets pin directions to match role; the port drives its own output enables
// R3 - spi setup from control and status bits
// R4 - master, slave, polarity, sample, edge, rate, select
// R5 - shift register moves data msb first
// R6 - full byte goes to buffer, flags set
// R7 - next byte shifts while old unread
// R8 - buffer write during transfer sets collision
// R9 - writes fail while collision flag set
// R10 - reading buffer clears full flag
// R11 - shift register reached only through buffer
// R12 - general call address zero acked when enabled
// R13 - general call raises port interrupt flag
// R14 - ten-bit general call keeps update flag
// R15 - address hold stretches clock after eighth fall
// R16 - zero mask bits make address don't-care
// R17 - address mask resets to all ones
// R18 - mask covers low address byte only
// R19 - master buffer write starts eight-clock transfer
`default_nettype none

module sync_serial_port (
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control bits
    input  wire logic       port_enable_bit,
    input  wire logic       i2c_mode,
    input  wire logic       master_mode,
    input  wire logic       clk_idle_high,
    input  wire logic       sample_at_end,
    input  wire logic       tx_on_trail_edge,
    input  wire logic [1:0] clk_rate_sel,
    input  wire logic       slave_select_en,
    input  wire logic       ten_bit_mode,
    input  wire logic       general_call_enable,
    input  wire logic       address_hold_enable,
    input  wire logic       ack_value_bit,
    input  wire logic [7:0] own_address_reg,
    // software strobes
    input  wire logic       buf_wr,
    input  wire logic [7:0] buf_wdata,
    input  wire logic       buf_rd,
    input  wire logic       int_flag_clr,
    input  wire logic       collision_clr,
    input  wire logic       upd_addr_clr,
    input  wire logic       ack_release,
    input  wire logic       mask_wr,
    input  wire logic [7:0] mask_wdata,
    // pins
    input  wire logic       sck_in,
    input  wire logic       serial_data_in,
    input  wire logic       ss_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // status
    output logic [7:0]      data_buffer,
    output logic            buffer_full_flag,
    output logic            port_interrupt_flag,
    output logic            write_collision_flag,
    output logic            update_address_flag,
    output logic            general_call_flag,
    output logic            busy,
    output logic [7:0]      address_mask_reg,
    // pin drivers
    output logic            sck_out,
    output logic            sck_oe,
    output logic            serial_data_out,
    output logic            serial_data_out_oe,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe
);

    typedef struct packed {
        ssp_pkg::spi_st_e spi;
        ssp_pkg::i2c_st_e i2c;
        logic [7:0]       shreg;
        logic [7:0]       dbuf;
        logic [3:0]       cnt;
        logic [3:0]       icnt;
        logic [5:0]       div;
        logic [4:0]       edges;
        logic             sck;
        logic             sck_oe;
        logic             dout;
        logic             dout_oe;
        logic             full;
        logic             irq;
        logic             collide;
        logic             upd_addr;
        logic             gcall;
        logic             hold;
        logic             ten_lo;
        logic             scl_oe;
        logic             sda_oe;
        logic             od_lvl;
        logic [7:0]       mask;
    } port_s;

    // idle, mask transparent
    localparam port_s RESET_STATE = '{
        spi: ssp_pkg::SPI_IDLE,
        i2c: ssp_pkg::I2C_IDLE,
        shreg: 8'h00,
        dbuf: 8'h00,
        cnt: 4'h0,
        icnt: 4'h0,
        div: 6'h00,
        edges: 5'h00,
        sck: 1'b0,
        sck_oe: 1'b0,
        dout: 1'b0,
        dout_oe: 1'b0,
        full: 1'b0,
        irq: 1'b0,
        collide: 1'b0,
        upd_addr: 1'b0,
        gcall: 1'b0,
        hold: 1'b0,
        ten_lo: 1'b0,
        scl_oe: 1'b0,
        sda_oe: 1'b0,
        od_lvl: 1'b0,
        mask: ssp_pkg::MASK_RESET
    };

    port_s s_reg;
    port_s s_next;

    pin_sync_if #(.W(ssp_pkg::PIN_W)) ps ();

    // pins synchronised before use
    assign ps.raw[ssp_pkg::PIN_SCK] = sck_in;
    assign ps.raw[ssp_pkg::PIN_SDI] = serial_data_in;
    assign ps.raw[ssp_pkg::PIN_SS]  = ss_n_in;
    assign ps.raw[ssp_pkg::PIN_SCL] = scl_in;
    assign ps.raw[ssp_pkg::PIN_SDA] = sda_in;

    pin_sampler #(.W(ssp_pkg::PIN_W)) u_pins (
        .clk   (clk),
        .rst_n (rst_n),
        .pins  (ps.sampler)
    );

    // master half period
    function automatic logic [5:0] rate_half(input logic [1:0] sel);
        case (sel)
            2'h0:    rate_half = ssp_pkg::HALF_DIV4;
            2'h1:    rate_half = ssp_pkg::HALF_DIV16;
            default: rate_half = ssp_pkg::HALF_DIV64;
        endcase
    endfunction

    logic [5:0] half;
    logic       spi_on;
    logic       i2c_on;
    logic       selected;
    logic       m_edge;
    logic       lead;
    logic       trail;
    logic       tx_e;
    logic       rx_e;
    logic       start_c;
    logic       stop_c;
    logic       gc_hit;
    logic       m7;
    logic       m10_lo;
    logic       m10_hi;
    logic       matched;

    // address comparators
    always_comb begin
        gc_hit = general_call_enable && (s_reg.shreg == ssp_pkg::GEN_CALL_ADDR); // [R12]
        m7 = (((s_reg.shreg[7:1] ^ own_address_reg[7:1]) & s_reg.mask[7:1]) == 7'h00); // [R16] [R18]
        m10_lo = (((s_reg.shreg ^ own_address_reg) & s_reg.mask) == 8'h00); // [R16] [R18]
        // ten-bit high byte unmasked
        m10_hi = (s_reg.shreg[7:1] == own_address_reg[7:1]); // [R18]
        if (gc_hit) begin
            matched = 1'b1;
        end else if (!ten_bit_mode) begin
            matched = m7;
        end else begin
            matched = s_reg.ten_lo ? m10_lo : m10_hi;
        end
    end

    // next state of the whole port
    always_comb begin
        s_next   = s_reg;
        half     = rate_half(clk_rate_sel);
        spi_on   = port_enable_bit && !i2c_mode; // [R1]
        i2c_on   = port_enable_bit && i2c_mode; // [R1]
        selected = !slave_select_en || !ps.lvl[ssp_pkg::PIN_SS];
        m_edge   = 1'b0;
        start_c  = ps.fall[ssp_pkg::PIN_SDA] && ps.lvl[ssp_pkg::PIN_SCL];
        stop_c   = ps.rise[ssp_pkg::PIN_SDA] && ps.lvl[ssp_pkg::PIN_SCL];

        // clears first: a same-cycle set wins
        if (buf_rd) begin
            s_next.full = 1'b0; // [R10]
        end
        if (int_flag_clr) begin
            s_next.irq = 1'b0;
        end
        if (collision_clr) begin
            s_next.collide = 1'b0; // [R9]
        end
        if (upd_addr_clr) begin
            s_next.upd_addr = 1'b0;
        end
        if (mask_wr) begin
            s_next.mask = mask_wdata;
        end

        // master divider or slave clock edges
        if (master_mode) begin
            if (s_reg.spi == ssp_pkg::SPI_XFER) begin
                if (s_reg.div == half - 6'h01) begin // [R4]
                    s_next.div   = 6'h00;
                    s_next.sck   = ~s_reg.sck;
                    s_next.edges = s_reg.edges + 5'h01;
                    m_edge       = 1'b1;
                end else begin
                    s_next.div = s_reg.div + 6'h01;
                end
            end
            lead  = m_edge && (s_reg.sck == clk_idle_high);
            trail = m_edge && (s_reg.sck != clk_idle_high);
        end else begin
            lead  = selected && (clk_idle_high ? ps.fall[ssp_pkg::PIN_SCK] : ps.rise[ssp_pkg::PIN_SCK]);
            trail = selected && (clk_idle_high ? ps.rise[ssp_pkg::PIN_SCK] : ps.fall[ssp_pkg::PIN_SCK]);
        end

        // output edge, sample middle or end
        tx_e = tx_on_trail_edge ? trail : lead; // [R3] [R4]
        if (master_mode && sample_at_end) begin
            rx_e = tx_e; // [R4]
        end else begin
            rx_e = tx_on_trail_edge ? lead : trail;
        end

        if (spi_on) begin
            // in at bottom, out at top
            if (rx_e) begin
                s_next.shreg = {s_reg.shreg[6:0], ps.lvl[ssp_pkg::PIN_SDI]}; // [R5]
                s_next.cnt   = s_reg.cnt + 4'h1;
                s_next.spi   = ssp_pkg::SPI_XFER;
                if (s_reg.cnt == ssp_pkg::BYTE_BITS - 4'h1) begin
                    // next byte may shift in unread
                    s_next.dbuf = s_next.shreg; // [R6] [R7]
                    s_next.full = 1'b1; // [R6]
                    s_next.irq  = 1'b1; // [R6]
                    s_next.cnt  = 4'h0;
                    if (!master_mode) begin
                        s_next.spi = ssp_pkg::SPI_IDLE;
                    end
                end
            end
            if (tx_e) begin
                s_next.dout = s_next.shreg[7]; // [R5]
            end
            // master ends after 16 edges
            if (master_mode && m_edge && s_reg.edges == ssp_pkg::MASTER_EDGES - 5'h01) begin
                s_next.spi   = ssp_pkg::SPI_IDLE; // [R19]
                s_next.edges = 5'h00;
            end
            // deselect drops partial byte
            if (!master_mode && !selected) begin
                s_next.cnt = 4'h0; // [R4]
                s_next.spi = ssp_pkg::SPI_IDLE;
            end
            // shift register loads via buffer
            if (buf_wr) begin
                if (s_reg.spi == ssp_pkg::SPI_XFER) begin
                    s_next.collide = 1'b1; // [R8]
                end else if (!s_reg.collide) begin
                    s_next.dbuf  = buf_wdata; // [R11]
                    s_next.shreg = buf_wdata;
                    s_next.dout  = buf_wdata[7];
                    s_next.cnt   = 4'h0;
                    s_next.div   = 6'h00;
                    s_next.edges = 5'h00;
                    s_next.spi   = ssp_pkg::SPI_XFER; // [R19]
                end
            end
            s_next.sck_oe  = master_mode;
            s_next.dout_oe = master_mode || selected;
            if (s_next.spi == ssp_pkg::SPI_IDLE) begin
                s_next.sck = clk_idle_high; // [R4]
            end
        end else begin
            // disabled or in i2c: spi held in reset
            s_next.spi     = ssp_pkg::SPI_IDLE; // [R1]
            s_next.cnt     = 4'h0;
            s_next.div     = 6'h00;
            s_next.edges   = 5'h00;
            s_next.sck     = clk_idle_high;
            s_next.sck_oe  = 1'b0;
            s_next.dout_oe = 1'b0;
        end

        if (i2c_on) begin
            unique case (s_reg.i2c)
                ssp_pkg::I2C_IDLE, ssp_pkg::I2C_SKIP: begin
                    // wait for start
                end
                ssp_pkg::I2C_ADDR, ssp_pkg::I2C_DATA: begin
                    if (ps.rise[ssp_pkg::PIN_SCL]) begin
                        s_next.shreg = {s_reg.shreg[6:0], ps.lvl[ssp_pkg::PIN_SDA]}; // [R5]
                        s_next.icnt  = s_reg.icnt + 4'h1;
                    end
                    if (ps.fall[ssp_pkg::PIN_SCL] && s_reg.icnt == ssp_pkg::BYTE_BITS) begin
                        if (s_reg.i2c == ssp_pkg::I2C_DATA || matched) begin
                            s_next.dbuf = s_reg.shreg; // [R6]
                            s_next.full = 1'b1;
                            s_next.irq  = 1'b1; // [R13]
                            s_next.i2c  = ssp_pkg::I2C_ACK;
                            if (s_reg.i2c == ssp_pkg::I2C_ADDR) begin
                                s_next.gcall = gc_hit;
                                // general call: data follows
                                s_next.upd_addr = s_next.upd_addr | (ten_bit_mode && !gc_hit); // [R14]
                                s_next.ten_lo   = ten_bit_mode && !gc_hit && !s_reg.ten_lo; // [R14]
                            end
                            if (s_reg.i2c == ssp_pkg::I2C_ADDR && address_hold_enable) begin
                                s_next.hold   = 1'b1; // [R15]
                                s_next.scl_oe = 1'b1; // [R15]
                            end else begin
                                s_next.sda_oe = 1'b1; // [R12]
                            end
                        end else begin
                            s_next.i2c = ssp_pkg::I2C_SKIP;
                        end
                    end
                end
                ssp_pkg::I2C_ACK: begin
                    // software answers, frees clock
                    if (s_reg.hold && ack_release) begin
                        s_next.hold   = 1'b0; // [R15]
                        s_next.scl_oe = 1'b0;
                        s_next.sda_oe = !ack_value_bit; // [R15]
                    end
                    if (!s_reg.hold && ps.rise[ssp_pkg::PIN_SCL]) begin
                        s_next.icnt = s_reg.icnt + 4'h1;
                    end
                    if (!s_reg.hold && ps.fall[ssp_pkg::PIN_SCL] && s_reg.icnt == ssp_pkg::ACK_BIT) begin
                        s_next.sda_oe = 1'b0;
                        s_next.icnt   = 4'h0;
                        s_next.i2c    = s_reg.ten_lo ? ssp_pkg::I2C_ADDR : ssp_pkg::I2C_DATA;
                    end
                end
            endcase
            // start and stop override
            if (start_c) begin
                s_next.i2c    = ssp_pkg::I2C_ADDR;
                s_next.icnt   = 4'h0;
                s_next.ten_lo = 1'b0;
                s_next.hold   = 1'b0;
                s_next.scl_oe = 1'b0;
                s_next.sda_oe = 1'b0;
            end else if (stop_c) begin
                s_next.i2c    = ssp_pkg::I2C_IDLE;
                s_next.icnt   = 4'h0;
                s_next.hold   = 1'b0;
                s_next.scl_oe = 1'b0;
                s_next.sda_oe = 1'b0;
            end
        end else begin
            // never hold bus outside i2c
            s_next.i2c    = ssp_pkg::I2C_IDLE; // [R1]
            s_next.icnt   = 4'h0;
            s_next.hold   = 1'b0;
            s_next.ten_lo = 1'b0;
            s_next.scl_oe = 1'b0;
            s_next.sda_oe = 1'b0;
        end

        // open-drain pins only ever pull low
        s_next.od_lvl = 1'b0;
    end

    // mask all ones on reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= RESET_STATE; // [R17]
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state
    assign data_buffer          = s_reg.dbuf;
    assign buffer_full_flag     = s_reg.full;
    assign port_interrupt_flag  = s_reg.irq;
    assign write_collision_flag = s_reg.collide;
    assign update_address_flag  = s_reg.upd_addr;
    assign general_call_flag    = s_reg.gcall;
    assign busy                 = s_reg.spi[1]; // one-hot transfer bit
    assign address_mask_reg     = s_reg.mask;
    assign sck_out              = s_reg.sck;
    assign sck_oe               = s_reg.sck_oe;
    assign serial_data_out      = s_reg.dout;
    assign serial_data_out_oe   = s_reg.dout_oe;
    assign scl_out              = s_reg.od_lvl;
    assign scl_oe               = s_reg.scl_oe;
    assign sda_out              = s_reg.od_lvl;
    assign sda_oe               = s_reg.sda_oe;

endmodule

`default_nettype wire

// ===== tb.sv
// spi and i2c bench
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, port_enable_bit, i2c_mode, master_mode, clk_idle_high, sample_at_end, ack;
    logic tx_on_trail_edge, slave_select_en, ten_bit_mode, general_call_enable, address_hold_enable;
    logic ack_value_bit, sck_in, ss_n_in, scl_drv, sda_drv, buffer_full_flag, port_interrupt_flag;
    logic write_collision_flag, update_address_flag, general_call_flag, busy, sck_out, sck_oe;
    logic serial_data_out, serial_data_out_oe, scl_out, scl_oe, sda_out, sda_oe;
    logic [1:0] clk_rate_sel;
    logic [7:0] own_address_reg, buf_wdata, mask_wdata, stb, data_buffer, address_mask_reg, rx_byte;
    wire logic buf_wr, buf_rd, int_flag_clr, collision_clr, upd_addr_clr, ack_release, mask_wr, load;
    wire logic serial_data_in, scl_in, sda_in;
    int fail_count = 0;
    int num_checks = 0;
    // strobe vector; pulls win
    assign {load, mask_wr, ack_release, upd_addr_clr, collision_clr, int_flag_clr, buf_rd, buf_wr} = stb;
    assign scl_in = scl_drv & ~scl_oe;
    assign sda_in = sda_drv & ~sda_oe;
    sync_serial_port u_sync_serial_port (.*);
    spi_partner u_spi_partner (.sck(sck_out), .mosi(serial_data_out), .load(load), .load_byte(buf_wdata),
        .miso(serial_data_in), .rx_byte(rx_byte));
    always #4 clk = ~clk;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic pulse(input logic [7:0] m, input logic [7:0] d);
        @(posedge clk);
        buf_wdata <= d;
        mask_wdata <= d;
        stb <= m;
        @(posedge clk);
        stb <= 8'h00;
        @(negedge clk);
    endtask
    task automatic wait_idle;
        int n = 0;
        while (busy !== 1'h0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("busy end", 8'(busy), 8'h00);
    endtask
    task automatic half;
        repeat (8) @(posedge clk);
    endtask
    task automatic i2c_start;
        @(posedge clk);
        sda_drv <= 1'h0;
        half();
        scl_drv <= 1'h0;
    endtask
    task automatic i2c_bits(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            sda_drv <= b[i];
            half();
            scl_drv <= 1'h1;
            half();
            scl_drv <= 1'h0;
        end
    endtask
    // ninth clock waits out stretching
    task automatic i2c_ack(output logic a);
        int n = 0;
        @(posedge clk);
        sda_drv <= 1'h1;
        half();
        scl_drv <= 1'h1;
        while (scl_in !== 1'h1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        half();
        a = sda_in;
        scl_drv <= 1'h0;
    endtask
    task automatic i2c_stop;
        @(posedge clk);
        sda_drv <= 1'h0;
        half();
        scl_drv <= 1'h1;
        half();
        sda_drv <= 1'h1;
        half();
    endtask
    task automatic i2c_addr(input logic [7:0] b, input logic [7:0] exp, input string nm);
        logic a;
        i2c_start();
        i2c_bits(b);
        i2c_ack(a);
        check(nm, 8'(a), exp);
        i2c_stop();
    endtask
    initial begin
        {clk, rst_n, port_enable_bit, i2c_mode, master_mode, clk_idle_high, sample_at_end} = 7'h00;
        {slave_select_en, ten_bit_mode, general_call_enable, address_hold_enable, ack_value_bit} = 5'h00;
        {tx_on_trail_edge, ss_n_in, scl_drv, sda_drv, sck_in, clk_rate_sel} = 7'h79;
        {stb, buf_wdata, mask_wdata, own_address_reg} = 32'h000000A0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(negedge clk);
        check("mask reset", address_mask_reg, 8'hFF);
        @(posedge clk);
        {port_enable_bit, master_mode} <= 2'h3;
        pulse(8'h80, 8'h3C);
        pulse(8'h01, 8'hA5);
        check("busy", 8'(busy), 8'h01);
        check("out msb", 8'(serial_data_out), 8'h01);
        pulse(8'h01, 8'h11);
        check("collision", 8'(write_collision_flag), 8'h01);
        wait_idle();
        check("rx buffer", data_buffer, 8'h3C);
        check("full", 8'(buffer_full_flag), 8'h01);
        check("irq", 8'(port_interrupt_flag), 8'h01);
        check("partner rx", rx_byte, 8'hA5);
        pulse(8'h01, 8'h22);
        check("blocked", 8'(busy), 8'h00);
        pulse(8'h0C, 8'h00);
        // second byte, first unread, slower rate
        @(posedge clk);
        clk_rate_sel <= 2'h2;
        pulse(8'h80, 8'hC3);
        pulse(8'h01, 8'h5A);
        check("restart", 8'(busy), 8'h01);
        wait_idle();
        check("second rx", data_buffer, 8'hC3);
        check("second tx", rx_byte, 8'h5A);
        pulse(8'h06, 8'h00);
        check("read clears", 8'(buffer_full_flag), 8'h00);
        @(posedge clk);
        port_enable_bit <= 1'h0;
        pulse(8'h01, 8'h77);
        check("disabled", 8'(busy), 8'h00);
        // i2c address, general call, mask
        @(posedge clk);
        {port_enable_bit, i2c_mode, master_mode} <= 3'h6;
        i2c_addr(8'h00, 8'h01, "gc off");
        @(posedge clk);
        general_call_enable <= 1'h1;
        i2c_addr(8'h00, 8'h00, "gc ack");
        check("gc flag", 8'(general_call_flag), 8'h01);
        check("gc irq", 8'(port_interrupt_flag), 8'h01);
        pulse(8'h06, 8'h00);
        i2c_addr(8'hA6, 8'h01, "unmasked");
        pulse(8'h40, 8'hF9);
        i2c_addr(8'hA6, 8'h00, "masked");
        check("masked data", data_buffer, 8'hA6);
        @(posedge clk);
        address_hold_enable <= 1'h1;
        i2c_start();
        i2c_bits(8'h00);
        repeat (20) @(posedge clk);
        check("stretch", 8'(scl_oe), 8'h01);
        pulse(8'h20, 8'h00);
        i2c_ack(ack);
        check("held ack", 8'(ack), 8'h00);
        i2c_stop();
        @(posedge clk);
        {address_hold_enable, ten_bit_mode, own_address_reg} <= 10'h1F0;
        pulse(8'h16, 8'h00);
        i2c_addr(8'h00, 8'h00, "ten gc");
        check("ten gc upd", 8'(update_address_flag), 8'h00);
        i2c_addr(8'hF6, 8'h01, "high byte mask");
        i2c_addr(8'hF0, 8'h00, "high byte");
        check("ten upd", 8'(update_address_flag), 8'h01);
        finish_test();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
